// ===== common/nibble_core_consts.svh
/*
  Constants for the nibble core: bus offsets, boot vector, bank numbers,
  operand fields and machine-cycle dividers.
  Assumes inclusion by bare name from the design and the bench.
*/
`ifndef NIBBLE_CORE_CONSTS_SVH
`define NIBBLE_CORE_CONSTS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFF_CMD        5'h00
`define OFF_STATUS     5'h04
`define OFF_PC         5'h08
`define OFF_REGS       5'h0c
`define OFF_CLKCTL     5'h10
`define OFF_IRQ        5'h14
`define OFF_FLAGS      5'h18

// ------------------------------------------------------------------
// Boot vector and program counter
// ------------------------------------------------------------------
`define PC_RESET       14'h0000
`define BOOT_ADDR_HI   14'h0000
`define BANK_EN_BIT    7
`define TABLE_MIN      7'h20

// ------------------------------------------------------------------
// Banks and fixed areas
// ------------------------------------------------------------------
`define BANK_0         4'h0
`define BANK_1         4'h1
`define BANK_15        4'hf
`define FAST_PAGE_LO   4'hb
`define FAST_PAGE_HI   4'hf
`define PTR_PAGE_TOP   2'h3

// ------------------------------------------------------------------
// Relative branch reach
// ------------------------------------------------------------------
`define REL_MIN        6'sh31
`define REL_BACK_MAX   6'sh3f
`define REL_FWD_MIN    6'sh02
`define REL_FWD_MAX    6'sh10

// ------------------------------------------------------------------
// Skipped-instruction kinds
// ------------------------------------------------------------------
`define NEXT_SHORT     2'h0
`define NEXT_LONG      2'h1
`define NEXT_TABLE     2'h2

// ------------------------------------------------------------------
// Machine cycle dividers (clk periods less one)
// ------------------------------------------------------------------
`define MC_DIV_STEP0   4'hf
`define MC_DIV_STEP1   4'h1
`define MC_DIV_STEP2   4'h0
`define CLKCTL_RESET   2'h0
`define ZERO_NIBBLE    4'h0

`endif

// ===== common/nibble_core_pkg.sv
/*
  Types for the nibble core: controller states and command codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package nibble_core_pkg;

  // ------------------------------------------------------------------
  // Controller states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    st_rom_hi_wait,
    st_rom_hi,
    st_rom_lo_wait,
    st_rom_lo,
    st_mem_wait,
    st_mem,
    st_cycles,
    st_idle
  } state_e;

  // ------------------------------------------------------------------
  // Command codes, in code order 0 to 15
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    op_nop,
    op_add_with_carry,
    op_subtract_with_borrow,
    op_rotate_right_carry,
    op_load_mem,
    op_store_mem,
    op_load_hl,
    op_load_bank0,
    op_load_pair,
    op_test_fast_bit,
    op_test_ptr_bit,
    op_rel_branch,
    op_page_branch,
    op_table_indirect_instr,
    op_select_bank,
    op_set_bank_enable
  } op_e;

endpackage : nibble_core_pkg

// ===== rtl/nibble_core.sv
/*
  Nibble core control block: boot vector load, reset state, bank
  mapping, skip timing, branches, table indirection and nibble ALU.
  Assumes a synchronous program ROM and data RAM, each returning data
  one edge after the address register is loaded, and an Avalon-MM
  master on the same clock.
*/
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "nibble_core_consts.svh"

module nibble_core (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Avalon-MM register slave
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Program ROM port
  output logic      [13:0]           rom_addr,
  input  wire logic [7:0]            rom_rdata,
  // Data RAM port
  output logic      [11:0]           ram_addr,
  output logic                       ram_re,
  output logic                       ram_we,
  output logic      [3:0]            ram_wdata,
  input  wire logic [3:0]            ram_rdata,
  // Interrupt request sources, asynchronous
  input  wire logic [7:0]            irq_src,
  // Machine cycle strobe
  output logic                       mc_tick
);
  import nibble_core_pkg::*;

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [3:0] direct_bank(input logic       bank_en,
                                             input logic [3:0] sel,
                                             input logic [7:0] addr);
    logic [3:0] b;
    b = sel;
    if (!bank_en) begin
      b = addr[7] ? `BANK_15 : `BANK_0;
    end
    return b;
  endfunction : direct_bank

  function automatic logic [1:0] skip_extra(input logic taken, input logic [1:0] kind);
    logic [1:0] s;
    s = 2'h0;
    if (taken) begin
      s = (kind == `NEXT_LONG) ? 2'h2 : 2'h1;
    end
    return s;
  endfunction : skip_extra

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  state_e      state_r, state_nxt;
  logic [13:0] pc_r, pc_nxt;
  logic        bank_en_r, bank_en_nxt;
  logic [3:0]  bank_sel_r, bank_sel_nxt;
  logic [2:0]  skip_flags_r, skip_flags_nxt;
  logic        int_status_r, int_status_nxt;
  logic        gie_r, gie_nxt;
  logic [7:0]  src_en_r, src_en_nxt;
  logic [7:0]  src_req_r, src_req_nxt;
  logic [1:0]  clkctl_r, clkctl_nxt;
  logic [3:0]  div_r, div_nxt;
  logic [2:0]  cyc_r, cyc_nxt;
  logic        table_r, table_nxt;
  logic        err_r, err_nxt;
  op_e         op_r, op_nxt;
  logic [11:0] arg_r, arg_nxt;
  logic [5:0]  rom_hi_r, rom_hi_nxt;
  logic [13:0] rom_addr_r, rom_addr_nxt;
  logic [11:0] ram_addr_r, ram_addr_nxt;
  logic        ram_re_r, ram_re_nxt;
  logic        ram_we_r, ram_we_nxt;
  logic [3:0]  ram_wdata_r, ram_wdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rd_done_r, rd_done_nxt;
  logic [7:0]  irq_s1_r, irq_s2_r;
  // Working registers X A B C D E H L and carry: no reset
  logic [3:0]  wreg_r [8];
  logic [3:0]  wreg_nxt [8];
  logic        carry_r, carry_nxt;

  logic        busy;
  logic        cmd_sel;
  logic        wr_ok;
  logic [31:0] rd_mux;
  logic [31:0] regs_word;
  logic [4:0]  alu_sum;
  logic [3:0]  hl_bank;
  logic        bit_val;

  assign busy            = (state_r != st_idle);
  assign cmd_sel         = (avs_address == `OFF_CMD);
  assign avs_waitrequest = (avs_write & cmd_sel & busy) | (avs_read & ~rd_done_r);
  assign wr_ok           = avs_write & ~avs_waitrequest;
  assign regs_word       = {wreg_r[0], wreg_r[1], wreg_r[2], wreg_r[3],
                            wreg_r[4], wreg_r[5], wreg_r[6], wreg_r[7]};
  assign hl_bank         = {4{bank_en_r}} & bank_sel_r;
  assign mc_tick         = (div_r == `ZERO_NIBBLE);
  assign avs_readdata    = rdata_r;
  assign rom_addr        = rom_addr_r;
  assign ram_addr        = ram_addr_r;
  assign ram_re          = ram_re_r;
  assign ram_we          = ram_we_r;
  assign ram_wdata       = ram_wdata_r;

  // ------------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------------
  always_comb begin
    case (avs_address)
      `OFF_STATUS: rd_mux = {20'h0, bank_sel_r, carry_r, int_status_r, bank_en_r,
                             skip_flags_r, err_r, busy};
      `OFF_PC:     rd_mux = {18'h0, pc_r};
      `OFF_REGS:   rd_mux = regs_word;
      `OFF_CLKCTL: rd_mux = {30'h0, clkctl_r};
      `OFF_IRQ:    rd_mux = {15'h0, src_req_r, src_en_r, gie_r};
      `OFF_FLAGS:  rd_mux = {30'h0, bank_en_r, carry_r};
      default:     rd_mux = 32'h0;
    endcase
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [5:0]  off;
    wv             = 32'h0;
    off            = 6'h0;
    state_nxt      = state_r;
    pc_nxt         = pc_r;
    bank_en_nxt    = bank_en_r;
    bank_sel_nxt   = bank_sel_r;
    skip_flags_nxt = skip_flags_r;
    int_status_nxt = int_status_r;
    gie_nxt        = gie_r;
    src_en_nxt     = src_en_r;
    src_req_nxt    = src_req_r | irq_s2_r;
    clkctl_nxt     = clkctl_r;
    cyc_nxt        = cyc_r;
    table_nxt      = table_r;
    err_nxt        = err_r;
    op_nxt         = op_r;
    arg_nxt        = arg_r;
    rom_hi_nxt     = rom_hi_r;
    rom_addr_nxt   = rom_addr_r;
    ram_addr_nxt   = ram_addr_r;
    ram_re_nxt     = 1'b0;
    ram_we_nxt     = 1'b0;
    ram_wdata_nxt  = ram_wdata_r;
    carry_nxt      = carry_r;
    for (int i = 0; i < 8; i++) begin
      wreg_nxt[i] = wreg_r[i];
    end
    alu_sum        = 5'h0;
    bit_val        = 1'b0;

    // Machine cycle divider, three steps, values 2 and 3 alike
    case (clkctl_r)
      2'h0:    div_nxt = mc_tick ? `MC_DIV_STEP0 : 4'(div_r - 4'h1);
      2'h1:    div_nxt = mc_tick ? `MC_DIV_STEP1 : 4'(div_r - 4'h1);
      default: div_nxt = `MC_DIV_STEP2;
    endcase

    // Register writes from the bus
    if (wr_ok) begin
      case (avs_address)
        `OFF_REGS: begin
          wv = be_merge(regs_word, avs_writedata, avs_byteenable);
          for (int i = 0; i < 8; i++) begin
            wreg_nxt[i] = wv[(7 - i)*4 +: 4];
          end
        end
        `OFF_CLKCTL: begin
          if (avs_byteenable[0]) begin
            clkctl_nxt = avs_writedata[1:0];
          end
        end
        `OFF_IRQ: begin
          wv          = be_merge({15'h0, 8'h0, src_en_r, gie_r}, avs_writedata,
                                 avs_byteenable);
          gie_nxt     = wv[0];
          src_en_nxt  = wv[8:1];
          // Write 1 clears a request; a new request in the same cycle wins
          src_req_nxt = (src_req_r & ~(avs_writedata[16:9] &
                         {8{avs_byteenable[1] & avs_byteenable[2]}})) | irq_s2_r;
        end
        `OFF_FLAGS: begin
          if (avs_byteenable[0]) begin
            carry_nxt   = avs_writedata[0];
            bank_en_nxt = avs_writedata[1];
          end
        end
        default: begin
        end
      endcase
    end

    case (state_r)
      // Vector and table words: high word then low word
      st_rom_hi_wait: state_nxt = st_rom_hi;
      st_rom_hi: begin
        rom_hi_nxt = rom_rdata[5:0];
        if (!table_r) begin
          bank_en_nxt = rom_rdata[`BANK_EN_BIT];
        end
        rom_addr_nxt = 14'(rom_addr_r + 14'h1);
        state_nxt    = st_rom_lo_wait;
      end
      st_rom_lo_wait: state_nxt = st_rom_lo;
      st_rom_lo: begin
        pc_nxt    = {rom_hi_r, rom_rdata};
        state_nxt = table_r ? st_cycles : st_idle;
      end
      st_mem_wait: state_nxt = st_mem;
      st_mem: begin
        state_nxt = st_cycles;
        bit_val   = ram_rdata[arg_r[6:5]];
        case (op_r)
          op_add_with_carry: begin
            alu_sum     = 5'(wreg_r[1] + ram_rdata + {3'h0, carry_r});
            wreg_nxt[1] = alu_sum[3:0];
            carry_nxt   = alu_sum[4];
          end
          op_subtract_with_borrow: begin
            alu_sum     = 5'(wreg_r[1] - ram_rdata - {3'h0, carry_r});
            wreg_nxt[1] = alu_sum[3:0];
            carry_nxt   = alu_sum[4];
          end
          op_test_fast_bit, op_test_ptr_bit: begin
            if (op_r == op_test_ptr_bit) begin
              bit_val = ram_rdata[wreg_r[7][1:0]];
            end
            skip_flags_nxt = {arg_r[8:7] == `NEXT_TABLE, arg_r[8:7] == `NEXT_LONG, bit_val};
            cyc_nxt        = 3'(cyc_r + {1'b0, skip_extra(bit_val, arg_r[8:7])});
          end
          default: wreg_nxt[1] = ram_rdata;
        endcase
      end
      st_cycles: begin
        if (mc_tick) begin
          cyc_nxt = 3'(cyc_r - 3'h1);
          if (cyc_r == 3'h1) begin
            state_nxt = st_idle;
            table_nxt = 1'b0;
          end
        end
      end
      st_idle: begin
        if (wr_ok && cmd_sel && avs_byteenable[0]) begin
          op_nxt         = op_e'(avs_writedata[3:0]);
          arg_nxt        = avs_writedata[15:4];
          err_nxt        = 1'b0;
          skip_flags_nxt = 3'h0;
          cyc_nxt        = 3'h1;
          state_nxt      = st_cycles;
          ram_wdata_nxt  = wreg_r[1];
          case (op_e'(avs_writedata[3:0]))
            op_add_with_carry, op_subtract_with_borrow, op_load_hl: begin
              ram_addr_nxt = {hl_bank, wreg_r[6], wreg_r[7]};
              ram_re_nxt   = 1'b1;
              state_nxt    = st_mem_wait;
            end
            op_rotate_right_carry: begin
              carry_nxt   = wreg_r[1][0];
              wreg_nxt[1] = {carry_r, wreg_r[1][3:1]};
            end
            op_load_mem, op_store_mem: begin
              cyc_nxt      = 3'h2;
              ram_addr_nxt = {direct_bank(bank_en_r, bank_sel_r, avs_writedata[11:4]),
                              avs_writedata[11:4]};
              ram_re_nxt   = (avs_writedata[3:0] == op_load_mem);
              ram_we_nxt   = (avs_writedata[3:0] == op_store_mem);
              state_nxt    = ram_re_nxt ? st_mem_wait : st_cycles;
            end
            op_load_bank0: begin
              ram_addr_nxt = {`BANK_0, wreg_r[4],
                              avs_writedata[4] ? wreg_r[7] : wreg_r[5]};
              ram_re_nxt   = 1'b1;
              state_nxt    = st_mem_wait;
            end
            op_load_pair: begin
              cyc_nxt = 3'h2;
              wreg_nxt[{avs_writedata[13:12], 1'b0}] = avs_writedata[11:8];
              wreg_nxt[{avs_writedata[13:12], 1'b1}] = avs_writedata[7:4];
            end
            op_test_fast_bit: begin
              cyc_nxt      = 3'h2;
              ram_addr_nxt = {`BANK_15, avs_writedata[8] ? `FAST_PAGE_HI : `FAST_PAGE_LO,
                              avs_writedata[7:4]};
              ram_re_nxt   = 1'b1;
              state_nxt    = st_mem_wait;
            end
            op_test_ptr_bit: begin
              cyc_nxt      = 3'h2;
              ram_addr_nxt = {`BANK_15, `PTR_PAGE_TOP, avs_writedata[7:4],
                              wreg_r[7][3:2]};
              ram_re_nxt   = 1'b1;
              state_nxt    = st_mem_wait;
            end
            op_rel_branch: begin
              cyc_nxt = 3'h2;
              off     = avs_writedata[9:4];
              if (($signed(off) >= `REL_MIN && $signed(off) <= `REL_BACK_MAX) ||
                  ($signed(off) >= `REL_FWD_MIN && $signed(off) <= `REL_FWD_MAX)) begin
                pc_nxt = 14'(pc_r + {{8{off[5]}}, off});
              end else begin
                err_nxt = 1'b1;
              end
            end
            op_page_branch: begin
              cyc_nxt = 3'h2;
              pc_nxt  = {pc_r[13:12], avs_writedata[15:4]};
            end
            op_table_indirect_instr: begin
              cyc_nxt = 3'h1;
              if (!avs_writedata[4] && avs_writedata[10:4] >= `TABLE_MIN) begin
                rom_addr_nxt = {7'h0, avs_writedata[10:4]};
                table_nxt    = 1'b1;
                state_nxt    = st_rom_hi_wait;
              end else begin
                err_nxt = 1'b1;
              end
            end
            op_select_bank: begin
              cyc_nxt = 3'h2;
              if (avs_writedata[7:4] == `BANK_0 || avs_writedata[7:4] == `BANK_1 ||
                  avs_writedata[7:4] == `BANK_15) begin
                bank_sel_nxt = avs_writedata[7:4];
              end else begin
                err_nxt = 1'b1;
              end
            end
            op_set_bank_enable: bank_en_nxt = avs_writedata[4];
            default: begin
            end
          endcase
        end
      end
      default: state_nxt = st_idle;
    endcase

    rd_done_nxt = avs_read & ~rd_done_r;
    rdata_nxt   = (avs_read & ~rd_done_r) ? rd_mux : rdata_r;
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= st_rom_hi_wait;
      pc_r         <= `PC_RESET;
      bank_en_r    <= 1'b0;
      bank_sel_r   <= `BANK_0;
      skip_flags_r <= 3'h0;
      int_status_r <= 1'b0;
      gie_r        <= 1'b0;
      src_en_r     <= 8'h0;
      src_req_r    <= 8'h0;
      clkctl_r     <= `CLKCTL_RESET;
      div_r        <= `MC_DIV_STEP0;
      cyc_r        <= 3'h0;
      table_r      <= 1'b0;
      err_r        <= 1'b0;
      op_r         <= op_nop;
      arg_r        <= 12'h0;
      rom_hi_r     <= 6'h0;
      rom_addr_r   <= `BOOT_ADDR_HI;
      ram_addr_r   <= 12'h0;
      ram_re_r     <= 1'b0;
      ram_we_r     <= 1'b0;
      ram_wdata_r  <= 4'h0;
      rdata_r      <= 32'h0;
      rd_done_r    <= 1'b0;
      irq_s1_r     <= 8'h0;
      irq_s2_r     <= 8'h0;
    end else begin
      state_r      <= state_nxt;
      pc_r         <= pc_nxt;
      bank_en_r    <= bank_en_nxt;
      bank_sel_r   <= bank_sel_nxt;
      skip_flags_r <= skip_flags_nxt;
      int_status_r <= int_status_nxt;
      gie_r        <= gie_nxt;
      src_en_r     <= src_en_nxt;
      src_req_r    <= src_req_nxt;
      clkctl_r     <= clkctl_nxt;
      div_r        <= div_nxt;
      cyc_r        <= cyc_nxt;
      table_r      <= table_nxt;
      err_r        <= err_nxt;
      op_r         <= op_nxt;
      arg_r        <= arg_nxt;
      rom_hi_r     <= rom_hi_nxt;
      rom_addr_r   <= rom_addr_nxt;
      ram_addr_r   <= ram_addr_nxt;
      ram_re_r     <= ram_re_nxt;
      ram_we_r     <= ram_we_nxt;
      ram_wdata_r  <= ram_wdata_nxt;
      rdata_r      <= rdata_nxt;
      rd_done_r    <= rd_done_nxt;
      irq_s1_r     <= irq_src;
      irq_s2_r     <= irq_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // Working registers and carry, held through reset
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      wreg_r[i] <= wreg_nxt[i];
    end
    carry_r <= carry_nxt;
  end

endmodule : nibble_core

// ===== verif/mem_model.sv
/* Program ROM and data RAM beside the core.
   Assumes the core's registered addresses and one-cycle read latency. */
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk,
  input  wire logic [13:0] rom_addr,
  output logic      [7:0]  rom_rdata,
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_re,
  input  wire logic        ram_we,
  input  wire logic [3:0]  ram_wdata,
  output logic      [3:0]  ram_rdata = 4'h0
);
  logic [7:0] rom [0:255];
  logic [3:0] ram [0:4095];
  // RAM read data lasts one cycle, then turns to garbage; ROM data follows the address
  always @(posedge clk) begin
    rom_rdata <= rom[rom_addr[7:0]];
    if (ram_we) ram[ram_addr] <= ram_wdata;
    ram_rdata <= ram_re ? ram[ram_addr] : ~ram_rdata;
  end
endmodule : mem_model

// ===== verif/nibble_core_checker.sv
/* Port checks for nibble_core.
   Assumes the bind at the foot of this file. */
`timescale 1ns/1ps
`include "nibble_core_consts.svh"
module nibble_core_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [13:0] rom_addr,
  input wire logic [11:0] ram_addr,
  input wire logic        ram_re,
  input wire logic        ram_we,
  input wire logic        mc_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_boot; $rose(rst_b) |-> rom_addr == 14'h0 ##[1:2] rom_addr == 14'h1; endproperty
  a_boot: assert property (p_boot) else $error("boot fetch order");
  property p_nowr; $rose(rst_b) |-> !ram_we [*4]; endproperty
  a_nowr: assert property (p_nowr) else $error("ram write at boot");
  property p_bank; ram_re || ram_we |-> ram_addr[11:8] inside {4'h0, 4'h1, 4'hf}; endproperty
  a_bank: assert property (p_bank) else $error("illegal bank");
  property p_rdw; avs_read && !$past(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_rdw: assert property (p_rdw) else $error("read wait");
  property p_wrw; avs_write && avs_address != `OFF_CMD |-> !avs_waitrequest; endproperty
  a_wrw: assert property (p_wrw) else $error("write stalled");
  property p_tick; mc_tick |=> ##[0:15] mc_tick; endproperty
  a_tick: assert property (p_tick) else $error("machine cycle late");
  property p_rwx; ram_re |-> !ram_we ##1 !ram_re; endproperty
  a_rwx: assert property (p_rwx) else $error("ram strobe");
  property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
  a_hold: assert property (p_hold) else $error("readdata moved");
endmodule : nibble_core_checker
bind nibble_core nibble_core_checker chk_i (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .rom_addr, .ram_addr, .ram_re, .ram_we, .mc_tick);

// ===== verif/tb.sv
/* Bench for nibble_core over the register bus.
   Assumes mem_model as ROM and RAM. */
`timescale 1ns/1ps
`include "nibble_core_consts.svh"
module tb;
  logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, ram_re, ram_we, mc_tick, c;
  logic [4:0]  avs_address, s;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [13:0] rom_addr;
  logic [11:0] ram_addr;
  logic [7:0]  rom_rdata, irq_src;
  logic [3:0]  ram_wdata, ram_rdata, a;
  int          fails, n_checks, k, nw;
  nibble_core uut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .rom_addr, .rom_rdata,
    .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_rdata, .irq_src, .mc_tick);
  mem_model pm (.clk, .rom_addr, .rom_rdata, .ram_addr, .ram_re, .ram_we, .ram_wdata, .ram_rdata);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic [4:0] ad, input logic rd, input logic [31:0] d);
    logic w;
    w = 1'b1;
    nw = 0;
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      w = avs_waitrequest;
      q = avs_readdata;
      if (w === 1'b0) break;
      nw++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0) begin
      fails++;
      finish_test();
    end
  endtask : xfer
  task automatic run(input logic [3:0] op, input logic [11:0] opd);
    xfer(`OFF_CMD, 1'b0, {16'h0, opd, op});
    for (int i = 0; i < 50; i++) begin
      xfer(`OFF_STATUS, 1'b1, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk("idle", q[0], 1'b0);
    if (q[0] !== 1'b0) finish_test();
  endtask : run
  task automatic chk_ac;
    xfer(`OFF_REGS, 1'b1, 32'h0);
    chk("acc", q[27:24], a);
    xfer(`OFF_STATUS, 1'b1, 32'h0);
    chk("carry", q[7], c);
  endtask : chk_ac
  initial begin
    {rst_b, avs_read, avs_write, avs_address, avs_writedata, irq_src, fails, n_checks} = '0;
    {pm.rom[0], pm.rom[1], pm.rom[32], pm.rom[33]} = 32'hb53c1234;
    {pm.ram[12'h020], pm.ram[12'hf20], pm.ram[12'hf90], pm.ram[12'hfb3]} = 16'h9354;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    run(4'h0, 12'h0);
    chk("boot", {q[11:8], q[6:2]}, 9'h008);
    xfer(`OFF_PC, 1'b1, 32'h0);
    chk("pc", q[13:0], 14'h353c);
    xfer(`OFF_IRQ, 1'b1, 32'h0);
    chk("irq", q[16:0], 17'h0);
    xfer(`OFF_CLKCTL, 1'b1, 32'h0);
    chk("clkctl", q[1:0], 2'h0);
    xfer(`OFF_CLKCTL, 1'b0, 32'h2);
    xfer(`OFF_REGS, 1'b0, 32'h07002020);
    xfer(`OFF_FLAGS, 1'b0, 32'h3);
    {c, a} = 5'h17;
    run(4'h1, 12'h0);
    s = {1'b0, a} + 5'h9 + c;
    {c, a} = s;
    chk_ac();
    run(4'h2, 12'h0);
    s = {1'b0, a} - 5'h9 - c;
    {c, a} = s;
    chk_ac();
    run(4'h3, 12'h0);
    {a, c} = {c, a};
    chk_ac();
    run(4'he, 12'h00f);
    run(4'h6, 12'h0);
    a = 4'h3;
    chk_ac();
    run(4'he, 12'h002);
    chk("badbank", {q[11:8], q[1]}, 5'h1f);
    run(4'h7, 12'h0);
    a = 4'h9;
    chk_ac();
    xfer(`OFF_FLAGS, 1'b0, 32'h1);
    run(4'h4, 12'h090);
    a = 4'h5;
    chk_ac();
    run(4'h5, 12'h040);
    chk("store", pm.ram[12'h040], a);
    for (k = 0; k < 3; k++) begin
      run(4'h9, {3'h0, k[1:0], 7'h43});
      chk("skip", q[4:2], {k == 2, k == 1, 1'b1});
      xfer(`OFF_CMD, 1'b0, {19'h0, k[1:0], 11'h439});
      xfer(`OFF_CMD, 1'b0, 32'h0);
      chk("skipcyc", nw, (k == 1) ? 5 : 4);
    end
    run(4'h9, 12'h003);
    chk("noskip", q[2], 1'b0);
    xfer(`OFF_CMD, 1'b0, 32'h39);
    xfer(`OFF_CMD, 1'b0, 32'h0);
    chk("noskipcyc", nw, 3);
    run(4'hc, 12'habc);
    run(4'hb, 12'h001);
    chk("relerr", q[1], 1'b1);
    run(4'hd, 12'h021);
    xfer(`OFF_PC, 1'b1, 32'h0);
    chk("page", q[13:0], 14'h3abc);
    run(4'hd, 12'h020);
    xfer(`OFF_PC, 1'b1, 32'h0);
    chk("table", q[13:0], 14'h1234);
    run(4'hb, 12'h031);
    xfer(`OFF_PC, 1'b1, 32'h0);
    chk("relback", q[13:0], 14'h1225);
    run(4'hb, 12'h010);
    xfer(`OFF_PC, 1'b1, 32'h0);
    chk("relfwd", q[13:0], 14'h1235);
    irq_src <= 8'h81;
    xfer(`OFF_IRQ, 1'b0, 32'h0001ffff);
    xfer(`OFF_IRQ, 1'b1, 32'h0);
    chk("irqset", q[16:0], 17'h103ff);
    xfer(`OFF_IRQ, 1'b0, 32'h0001ffff);
    xfer(`OFF_IRQ, 1'b1, 32'h0);
    chk("irqwin", q[16:9], 8'h81);
    irq_src <= 8'h00;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    run(4'h0, 12'h0);
    chk("rst2", q[11:5], {4'h0, c, 2'h1});
    xfer(`OFF_IRQ, 1'b1, 32'h0);
    chk("irq2", q[16:0], 17'h0);
    xfer(`OFF_CLKCTL, 1'b1, 32'h0);
    chk("clk2", q[1:0], 2'h0);
    xfer(`OFF_REGS, 1'b1, 32'h0);
    chk("regs", q, {4'h0, a, 24'h002020});
    chk("ram", pm.ram[12'h020], 4'h9);
    finish_test();
  end
endmodule : tb
